// ### hw/sbn_master.sv
// Master node link controller with its order payload FIFO
// What this block does
// - Only the master starts, always with an order
// - Master polls addressed slave until reply arrives
// - Slave addresses lie between 1 and 250
// - Exactly one master controls the whole bus
// - Mastership never handed across a repeater
// - Repeaters only in self-clocked mode
// - Synchronous rate between 500k and 2.4M
// - Data changes on clock fall, sampled on rise
// - Transmitting node drives the link clock
// - Self-clocked rate is 375k or 62.5k
// - Self-clocked data is NRZI, no clock line
// - Frames delimited and recognised by 01111110 flags
// - Zero inserted and removed after five ones
// - NRZI zero toggles line, one holds it
// - At least eight zeros precede each self-clocked frame
`timescale 1ns/1ns
`include "sbn_regs.svh"

module sbn_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [WIDTH-1:0]         in_data,
    input  wire logic                     in_valid,
    output logic                          in_ready,
    output logic [WIDTH-1:0]              out_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [$clog2(DEPTH):0]        level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign level     = wr_ptr - rd_ptr;
    assign in_ready  = (level != (AW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = mem[rd_ptr[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage has no reset, contents are don't care until written
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : sbn_fifo

module sbn_master #(
    parameter int RESP_WAIT = 200000
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       mode_self,
    input  wire logic       rate_slow,
    input  wire logic       req_start,
    input  wire logic [7:0] req_addr,
    input  wire logic [4:0] req_len,
    input  wire logic [7:0] in_data,
    input  wire logic       in_valid,
    output logic            in_ready,
    output logic            busy,
    output logic            done,
    output logic            refused,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            data_o,
    output logic            data_oe,
    input  wire logic       data_i,
    output logic            lclk_o,
    output logic            lclk_oe,
    input  wire logic       lclk_i
);
    sbn_pkg::sbn_state_t st, next_st;
    sbn_pkg::sbn_phase_t ph, next_ph;
    logic [10:0] tcnt, next_tcnt, per, half, rcnt, next_rcnt;
    logic [2:0]  bidx, next_bidx, ones, next_ones, rones, next_rones, rnb, next_rnb;
    logic [7:0]  sr, next_sr, addr, next_addr, ctrl, next_ctrl;
    logic [7:0]  raw, next_raw, rbyte, next_rbyte, radr, next_radr, rctl, next_rctl;
    logic [4:0]  pay, next_pay, lvl;
    logic [17:0] wcnt, next_wcnt;
    logic        line, next_line, tbit, next_tbit, clk_q, next_clk, next_refused;
    logic        bnd, emit, launch, bit_now, pop, fifo_valid;
    logic [7:0]  fifo_data, next_rx_data;
    logic [1:0]  rnum, next_rnum;
    logic        infr, next_infr, plvl, next_plvl, next_rx_valid;
    logic        fr_reply, next_fr_reply, fr_ack, next_fr_ack, samp, rbit;
    logic        d_s1, d_s2, d_s3, c_s1, c_s2, c_s3;

    // Bit period per mode; mode input must stay fixed while busy
    function automatic logic [10:0] sbn_period(input logic self_m, input logic slow);
        if (!self_m) begin
            return 11'(`SBN_SYNC_BIT_CYC);
        end
        return slow ? 11'(`SBN_SLOW_BIT_CYC) : 11'(`SBN_FAST_BIT_CYC);
    endfunction : sbn_period

    sbn_fifo #(.WIDTH(`SBN_FIFO_WIDTH), .DEPTH(`SBN_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (in_data),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop),
        .level     (lvl)
    );

    // This node is the sole master and never hands the role on
    assign per     = sbn_period(mode_self, rate_slow);
    assign half    = per >> 1;
    assign bnd     = (tcnt == 11'h000);
    assign busy    = (st != sbn_pkg::SBN_IDLE);
    assign done    = (st == sbn_pkg::SBN_DONE);
    assign data_o  = line;
    assign data_oe = (st == sbn_pkg::SBN_SEND);
    // No direction pair here: bias keeps repeaters facing out
    // Clock driven only by us while sending, sync mode only
    assign lclk_o  = clk_q;
    assign lclk_oe = (st == sbn_pkg::SBN_SEND) && !mode_self;

    // Pin synchronisers; third stage only for edges, clock chain resets to idle high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {d_s1, d_s2, d_s3} <= 3'h0;
            {c_s1, c_s2, c_s3} <= 3'h7;
        end else begin
            {d_s1, d_s2, d_s3} <= {data_i, d_s1, d_s2};
            {c_s1, c_s2, c_s3} <= {lclk_i, c_s1, c_s2};
        end
    end

    // Transaction sequencer and bit transmitter
    always_comb begin
        next_st = st; next_ph = ph; next_tcnt = tcnt; next_bidx = bidx;
        next_sr = sr; next_ones = ones; next_line = line; next_tbit = tbit;
        next_pay = pay; next_ctrl = ctrl; next_addr = addr; next_wcnt = wcnt;
        next_refused = 1'b0; next_clk = 1'b1; pop = 1'b0;
        emit = 1'b0; launch = 1'b0; bit_now = 1'b0;
        unique case (st)
            sbn_pkg::SBN_IDLE: begin
                if (req_start) begin
                    if (req_addr >= `SBN_ADDR_MIN && req_addr <= `SBN_ADDR_MAX
                        && lvl >= req_len) begin
                        next_addr = req_addr;
                        next_ctrl = `SBN_CTRL_ORDER;
                        next_pay  = req_len;
                        launch    = 1'b1;
                    end else begin
                        next_refused = 1'b1;
                    end
                end
            end
            sbn_pkg::SBN_SEND: begin
                next_tcnt = tcnt - 11'h001;
                if (bnd) begin
                    next_tcnt = per - 11'h001;
                    if (ph == sbn_pkg::SBN_PH_END) begin
                        next_st   = sbn_pkg::SBN_WAIT;
                        next_wcnt = '0;
                    end else if (ones == `SBN_STUFF_RUN) begin
                        emit      = 1'b1;
                        next_ones = 3'h0;
                    end else begin
                        emit      = 1'b1;
                        bit_now   = (ph == sbn_pkg::SBN_PH_SYNC) ? 1'b0 : sr[0];
                        next_sr   = {1'b0, sr[7:1]};
                        next_bidx = bidx + 3'h1;
                        // Only address, control and payload bits count toward stuffing
                        if (ph == sbn_pkg::SBN_PH_ADDR || ph == sbn_pkg::SBN_PH_CTRL
                            || ph == sbn_pkg::SBN_PH_DATA) begin
                            next_ones = bit_now ? ones + 3'h1 : 3'h0;
                        end else begin
                            next_ones = 3'h0;
                        end
                        if (bidx == `SBN_LAST_BIT) begin
                            unique case (ph)
                                sbn_pkg::SBN_PH_SYNC: begin
                                    next_ph = sbn_pkg::SBN_PH_OFLAG;
                                    next_sr = `SBN_FLAG;
                                end
                                sbn_pkg::SBN_PH_OFLAG: begin
                                    next_ph = sbn_pkg::SBN_PH_ADDR;
                                    next_sr = addr;
                                end
                                sbn_pkg::SBN_PH_ADDR: begin
                                    next_ph = sbn_pkg::SBN_PH_CTRL;
                                    next_sr = ctrl;
                                end
                                sbn_pkg::SBN_PH_CTRL, sbn_pkg::SBN_PH_DATA: begin
                                    // Payload is already buffered, so the line never starves
                                    if (pay != 5'h00) begin
                                        next_ph  = sbn_pkg::SBN_PH_DATA;
                                        next_sr  = fifo_data;
                                        pop      = fifo_valid;
                                        next_pay = pay - 5'h01;
                                    end else begin
                                        next_ph = sbn_pkg::SBN_PH_CFLAG;
                                        next_sr = `SBN_FLAG;
                                    end
                                end
                                default: next_ph = sbn_pkg::SBN_PH_END;
                            endcase
                        end
                    end
                end
                next_clk = (next_tcnt < half);
            end
            sbn_pkg::SBN_WAIT: begin
                next_wcnt = wcnt + 18'h00001;
                if (fr_reply) begin
                    next_st = sbn_pkg::SBN_DONE;
                end else if (fr_ack || wcnt == 18'(RESP_WAIT - 1)) begin
                    next_st   = sbn_pkg::SBN_GAP;
                    next_wcnt = '0;
                end
            end
            sbn_pkg::SBN_GAP: begin
                next_wcnt = wcnt + 18'h00001;
                if (wcnt == `SBN_POLL_GAP - 18'h00001) begin
                    next_ctrl = `SBN_CTRL_POLL;
                    next_pay  = 5'h00;
                    launch    = 1'b1;
                end
            end
            sbn_pkg::SBN_DONE: next_st = sbn_pkg::SBN_IDLE;
            default: next_st = sbn_pkg::SBN_IDLE;
        endcase
        if (launch) begin
            next_st   = sbn_pkg::SBN_SEND;
            next_ph   = mode_self ? sbn_pkg::SBN_PH_SYNC : sbn_pkg::SBN_PH_OFLAG;
            next_sr   = mode_self ? 8'h00 : `SBN_FLAG;
            next_bidx = 3'h0;
            next_tcnt = 11'h000;
            next_ones = 3'h0;
        end
        if (emit) begin
            next_tbit = bit_now;
            next_line = mode_self ? (bit_now ? line : !line) : bit_now;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= sbn_pkg::SBN_IDLE; ph <= sbn_pkg::SBN_PH_SYNC; tcnt <= 11'h000;
            bidx <= 3'h0; sr <= 8'h00; ones <= 3'h0; line <= 1'b1; tbit <= 1'b0;
            pay <= 5'h00; ctrl <= 8'h00; addr <= 8'h00; wcnt <= 18'h00000;
            refused <= 1'b0; clk_q <= 1'b1;
        end else begin
            st <= next_st; ph <= next_ph; tcnt <= next_tcnt;
            bidx <= next_bidx; sr <= next_sr; ones <= next_ones; line <= next_line;
            tbit <= next_tbit; pay <= next_pay; ctrl <= next_ctrl; addr <= next_addr;
            wcnt <= next_wcnt; refused <= next_refused; clk_q <= next_clk;
        end
    end

    // Receiver: slaves answer only while we wait for them
    assign samp = mode_self ? (rcnt == 11'h000 && !(d_s2 ^ d_s3))
                            : (c_s2 && !c_s3);
    assign rbit = mode_self ? (d_s2 == plvl) : d_s2;

    always_comb begin
        next_rcnt = rcnt; next_raw = raw; next_rones = rones; next_rbyte = rbyte;
        next_rnb = rnb; next_rnum = rnum; next_radr = radr; next_rctl = rctl;
        next_infr = infr; next_plvl = plvl; next_rx_data = rx_data;
        next_rx_valid = 1'b0; next_fr_reply = 1'b0; next_fr_ack = 1'b0;
        // Every line transition re-centres the sampling point; repeaters do not retime
        if (d_s2 ^ d_s3) begin
            next_rcnt = half;
        end else if (rcnt == 11'h000) begin
            next_rcnt = per - 11'h001;
        end else begin
            next_rcnt = rcnt - 11'h001;
        end
        if (st != sbn_pkg::SBN_WAIT) begin
            next_infr = 1'b0; next_rones = 3'h0; next_raw = 8'h00; next_plvl = d_s2;
        end else if (samp) begin
            next_plvl = d_s2;
            next_raw  = {rbit, raw[7:1]};
            if (next_raw == `SBN_FLAG) begin
                // Closing flag ends the frame; partial flag bits are dropped
                if (infr && rnum == 2'h2 && radr == addr) begin
                    next_fr_reply = (rctl == `SBN_CTRL_REPLY);
                    next_fr_ack   = (rctl == `SBN_CTRL_ACK);
                end
                next_infr = 1'b1; next_rnum = 2'h0; next_rnb = 3'h0; next_rones = 3'h0;
            end else if (rones == `SBN_STUFF_RUN && !rbit) begin
                next_rones = 3'h0;
            end else begin
                next_rones = rbit ? ((rones == 3'h7) ? rones : rones + 3'h1) : 3'h0;
                next_rbyte = {rbit, rbyte[7:1]};
                next_rnb   = rnb + 3'h1;
                if (rnb == `SBN_LAST_BIT && infr) begin
                    unique case (rnum)
                        2'h0: next_radr = next_rbyte;
                        2'h1: next_rctl = next_rbyte;
                        default: begin
                            next_rx_data  = next_rbyte;
                            next_rx_valid = (radr == addr && rctl == `SBN_CTRL_REPLY);
                        end
                    endcase
                    next_rnum = (rnum == 2'h2) ? rnum : rnum + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rcnt <= 11'h000; raw <= 8'h00; rones <= 3'h0; rbyte <= 8'h00; rnb <= 3'h0;
            rnum <= 2'h0; radr <= 8'h00; rctl <= 8'h00; infr <= 1'b0; plvl <= 1'b0;
            rx_data <= 8'h00; rx_valid <= 1'b0; fr_reply <= 1'b0; fr_ack <= 1'b0;
        end else begin
            rcnt <= next_rcnt; raw <= next_raw; rones <= next_rones; rbyte <= next_rbyte;
            rnb <= next_rnb; rnum <= next_rnum; radr <= next_radr; rctl <= next_rctl;
            infr <= next_infr; plvl <= next_plvl; rx_data <= next_rx_data;
            rx_valid <= next_rx_valid; fr_reply <= next_fr_reply; fr_ack <= next_fr_ack;
        end
    end

    // Checks on the driven side of the link
    a_order_first: assert property (@(posedge clk) disable iff (rst)
        $rose(busy) |-> ctrl == `SBN_CTRL_ORDER && st == sbn_pkg::SBN_SEND)
        else $error("transaction did not open with an order");
    a_poll_after_ack: assert property (@(posedge clk) disable iff (rst)
        (st == sbn_pkg::SBN_WAIT && fr_ack && !fr_reply) |=> st == sbn_pkg::SBN_GAP
        ##[60:70] (st == sbn_pkg::SBN_SEND && ctrl == `SBN_CTRL_POLL))
        else $error("no poll followed an acknowledgement");
    a_addr_range: assert property (@(posedge clk) disable iff (rst)
        (st == sbn_pkg::SBN_IDLE && req_start && (req_addr < `SBN_ADDR_MIN
        || req_addr > `SBN_ADDR_MAX)) |=> refused && !busy)
        else $error("out of range address accepted");
    a_clk_source: assert property (@(posedge clk) disable iff (rst)
        (!mode_self && $rose(data_oe)) |-> lclk_oe && lclk_o ##1 lclk_oe && !lclk_o
        ##24 lclk_oe && !lclk_o ##1 lclk_oe && lclk_o)
        else $error("link clock not driven while sending");
    a_clk_fall_data: assert property (@(posedge clk) disable iff (rst)
        (!mode_self && data_oe && $past(data_oe) && $changed(data_o)) |-> $fell(lclk_o))
        else $error("data changed away from clock fall");
    a_stuff_zero: assert property (@(posedge clk) disable iff (rst)
        (data_oe && bnd && ones == `SBN_STUFF_RUN && ph != sbn_pkg::SBN_PH_END)
        |=> !tbit && ones == 3'h0)
        else $error("no zero after five ones");
    a_nrzi_zero: assert property (@(posedge clk) disable iff (rst)
        (mode_self && data_oe && bnd && ph != sbn_pkg::SBN_PH_END)
        |=> (data_o != $past(data_o)) == !tbit)
        else $error("line polarity does not match coded bit");
    a_sync_first: assert property (@(posedge clk) disable iff (rst)
        (mode_self && $rose(data_oe)) |-> ph == sbn_pkg::SBN_PH_SYNC && bidx == 3'h0)
        else $error("frame not preceded by zero run");
endmodule : sbn_master

// ### hw/sbn_pkg.sv
// Types shared by the serial control bus master
package sbn_pkg;
    typedef enum logic [2:0] {
        SBN_IDLE = 3'h0,
        SBN_SEND = 3'h1,
        SBN_WAIT = 3'h3,
        SBN_DONE = 3'h7,
        SBN_GAP  = 3'h2
    } sbn_state_t;
    typedef enum logic [2:0] {
        SBN_PH_SYNC  = 3'h0,
        SBN_PH_OFLAG = 3'h1,
        SBN_PH_ADDR  = 3'h3,
        SBN_PH_CTRL  = 3'h2,
        SBN_PH_DATA  = 3'h6,
        SBN_PH_CFLAG = 3'h7,
        SBN_PH_END   = 3'h5
    } sbn_phase_t;
endpackage : sbn_pkg

// ### hw/sbn_regs.svh
// Constants of the serial control bus master: rates, codes and counts
`ifndef SBN_REGS_SVH
`define SBN_REGS_SVH
`define SBN_CLK_HZ        100000000
`define SBN_SYNC_BPS      2000000
`define SBN_SC_FAST_BPS   375000
`define SBN_SC_SLOW_BPS   62500
`define SBN_SYNC_BIT_CYC  (`SBN_CLK_HZ / `SBN_SYNC_BPS)
`define SBN_FAST_BIT_CYC  (`SBN_CLK_HZ / `SBN_SC_FAST_BPS)
`define SBN_SLOW_BIT_CYC  (`SBN_CLK_HZ / `SBN_SC_SLOW_BPS)
`define SBN_FLAG          8'h7E
`define SBN_ADDR_MIN      8'h01
`define SBN_ADDR_MAX      8'hFA
`define SBN_CTRL_ORDER    8'h01
`define SBN_CTRL_POLL     8'h02
`define SBN_CTRL_REPLY    8'h03
`define SBN_CTRL_ACK      8'h04
`define SBN_STUFF_RUN     3'h5
`define SBN_LAST_BIT      3'h7
`define SBN_POLL_GAP      18'h00040
`define SBN_FIFO_WIDTH    8
`define SBN_FIFO_DEPTH    16
`endif

// ### verification/sbn_slave_model.sv
// Behavioural slave node that answers the master in synchronous mode
`timescale 1ns/1ns

module sbn_slave_model (
    input  wire logic       clk,
    input  wire logic [7:0] slave_addr,
    input  wire logic [7:0] reply_data,
    input  wire logic [9:0] turn_cyc,
    input  wire logic       data_o,
    input  wire logic       lclk_o,
    input  wire logic       lclk_oe,
    output logic            data_i,
    output logic            lclk_i,
    output logic [7:0]      seen_byte,
    output logic            seen_valid
);
    logic [7:0] hist = 8'h00;
    logic [7:0] sr, addr_seen, ctrl_seen;
    logic       lclk_d = 1'b1;
    logic       frame_end = 1'b0;
    logic       polled = 1'b0;
    int         nbits, ones, nbytes, tx_ones;

    // Decode master frames at each link clock rise, dropping stuffed zeros
    always @(posedge clk) begin
        lclk_d <= lclk_o;
        seen_valid <= 1'b0;
        frame_end <= 1'b0;
        if (lclk_oe && lclk_o && !lclk_d) begin
            hist = {data_o, hist[7:1]};
            if (hist == 8'h7E) begin
                frame_end <= nbytes >= 2;
                nbits = 0;
                ones = 0;
                nbytes = 0;
            end else if (ones == 5 && !data_o) begin
                ones = 0;
            end else begin
                sr = {data_o, sr[7:1]};
                ones = data_o ? ones + 1 : 0;
                nbits++;
                if (nbits == 8) begin
                    nbits = 0;
                    if (nbytes == 0) addr_seen = sr;
                    if (nbytes == 1) ctrl_seen = sr;
                    nbytes++;
                    seen_byte <= sr;
                    seen_valid <= 1'b1;
                end
            end
        end
    end

    // Data moves while the clock is low, so it is steady at the rise
    task automatic send_bit(input logic b);
        lclk_i = 1'b0;
        data_i = b;
        repeat (4) @(posedge clk);
        #1 lclk_i = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask : send_bit

    task automatic send_byte(input logic [7:0] b, input logic stuff);
        for (int i = 0; i < 8; i++) begin
            send_bit(b[i]);
            tx_ones = b[i] ? tx_ones + 1 : 0;
            if (stuff && tx_ones == 5) begin
                send_bit(1'b0);
                tx_ones = 0;
            end
        end
    endtask : send_byte

    // Released data line wanders every cycle so a stale level never passes
    initial begin
        lclk_i = 1'b1;
        data_i = 1'b0;
        forever begin
            @(posedge clk);
            #1 data_i = ~data_i;
            if (frame_end && addr_seen === slave_addr) begin
                repeat (turn_cyc) begin
                    @(posedge clk);
                    #1 data_i = ~data_i;
                end
                @(posedge clk);
                #1;
                send_byte(8'h7E, 1'b0);
                tx_ones = 0;
                send_byte(slave_addr, 1'b1);
                if (ctrl_seen == 8'h02 && polled) begin
                    send_byte(8'h03, 1'b1);
                    send_byte(reply_data, 1'b1);
                end else begin
                    send_byte(8'h04, 1'b1);
                end
                polled = ctrl_seen == 8'h02 && !polled;
                send_byte(8'h7E, 1'b0);
            end
        end
    end
endmodule : sbn_slave_model

// ### verification/test_sbn_master.sv
// Self-checking bench for the bus master against a slave model
`timescale 1ns/1ns

module test_sbn_master;
    logic       clk, rst, mode_self, rate_slow, req_start, in_valid, in_ready, last;
    logic       busy, done, refused, rx_valid, data_o, data_oe, lclk_o, lclk_oe;
    logic       data_i, lclk_i, seen_valid;
    logic [7:0] req_addr, in_data, rx_data, slave_addr, reply_data, seen_byte;
    logic [4:0] req_len;
    logic [9:0] turn_cyc;
    logic [8:0] exp_link[$], exp_user[$];
    logic [7:0] pay_q[$];
    int         error_cnt, total_checks, cycles, toggles, seed;

    sbn_master #(.RESP_WAIT(20000)) u_sbn_master (
        .clk(clk), .rst(rst), .mode_self(mode_self), .rate_slow(rate_slow),
        .req_start(req_start), .req_addr(req_addr), .req_len(req_len),
        .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .busy(busy),
        .done(done), .refused(refused), .rx_data(rx_data), .rx_valid(rx_valid),
        .data_o(data_o), .data_oe(data_oe), .data_i(data_i), .lclk_o(lclk_o),
        .lclk_oe(lclk_oe), .lclk_i(lclk_i));

    sbn_slave_model u_sbn_slave_model (
        .clk(clk), .slave_addr(slave_addr), .reply_data(reply_data),
        .turn_cyc(turn_cyc), .data_o(data_o), .lclk_o(lclk_o), .lclk_oe(lclk_oe),
        .data_i(data_i), .lclk_i(lclk_i), .seen_byte(seen_byte), .seen_valid(seen_valid));

    always #5 clk = ~clk;

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Empty queue yields a value no result can match
    function automatic logic [8:0] take(ref logic [8:0] q[$]);
        return q.size() ? q.pop_front() : 9'h1FF;
    endfunction : take

    // Hang guard, well beyond the expected run of about 60k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // Each result seen on the wire or at the user side retires the oldest note
    always @(negedge clk) begin
        if (seen_valid) check({1'b0, seen_byte}, take(exp_link));
        if (rx_valid) check({1'b0, rx_data}, take(exp_user));
        if (done) check(9'h100, take(exp_user));
    end

    // Called just after an edge; valid stays up between bytes, caller lowers it
    task automatic push(input logic [7:0] b);
        logic ok;
        in_valid = 1'b1;
        in_data = b;
        pay_q.push_back(b);
        do begin
            @(negedge clk) ok = in_ready;
            @(posedge clk);
            #1;
        end while (!ok);
    endtask : push

    task automatic request(input logic [7:0] a, input logic [4:0] n, input logic ok);
        @(posedge clk);
        #1 req_start = 1'b1;
        req_addr = a;
        req_len = n;
        @(posedge clk);
        #1 req_start = 1'b0;
        check({7'h00, busy, refused}, {7'h00, ok, !ok});
        check({8'h00, data_oe}, {8'h00, ok});
    endtask : request

    // Order, ack, poll, ack, poll, reply: notes are queued before the start
    task automatic txn(input logic [7:0] a, input logic [4:0] n);
        exp_link.push_back({1'b0, a});
        exp_link.push_back(9'h001);
        repeat (n) exp_link.push_back({1'b0, pay_q.pop_front()});
        repeat (2) begin
            exp_link.push_back({1'b0, a});
            exp_link.push_back(9'h002);
        end
        slave_addr = a;
        reply_data = 8'($random(seed));
        turn_cyc = 10'(100 + {$random(seed)} % 500);
        exp_user.push_back({1'b0, reply_data});
        exp_user.push_back(9'h100);
        request(a, n, 1'b1);
        while (busy) begin
            @(posedge clk);
            #1;
        end
        check({7'h00, exp_link.size() == 0, exp_user.size() == 0}, 9'h003);
    endtask : txn

    initial begin
        seed = 32'h947B;
        {clk, rst, mode_self, rate_slow, req_start, in_valid} = 6'h10;
        {req_addr, req_len, in_data, slave_addr, reply_data} = '0;
        turn_cyc = 10'd100;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        // Idle levels straight after reset
        check({data_o, data_oe, lclk_o, lclk_oe, busy, in_ready, refused, done, rx_valid},
              9'h148);
        // Out-of-range addresses and a payload the FIFO lacks are refused
        request(8'h00, 5'h00, 1'b0);
        request(8'hFB, 5'h00, 1'b0);
        request(8'h01, 5'h01, 1'b0);
        // Fill the FIFO until it refuses, then drain it in one order
        for (int i = 0; i < 16; i++) push(8'($random(seed)));
        in_valid = 1'b0;
        check({8'h00, in_ready}, 9'h000);
        txn(8'(1 + {$random(seed)} % 250), 5'h10);
        check({8'h00, in_ready}, 9'h001);
        // Short payload refused, then back-to-back orders at the address ends
        push(8'h5A);
        in_valid = 1'b0;
        request(8'hFA, 5'h02, 1'b0);
        txn(8'hFA, 5'h01);
        txn(8'h01, 5'h00);
        // Self-clocked: preframe zeros and the flag's leading zero each change the line
        for (int r = 0; r < 2; r++) begin
            mode_self = 1'b1;
            rate_slow = r[0];
            last = data_o;
            toggles = 0;
            request(8'h20, 5'h00, 1'b1);
            repeat ((r ? 1600 : 266) * 15 - 5) begin
                toggles += int'(data_o !== last);
                last = data_o;
                if (lclk_oe !== 1'b0) toggles += 100;
                @(posedge clk);
                #1;
            end
            check(9'(toggles), 9'h009);
            rst = 1'b1;
            @(posedge clk);
            #1 rst = 1'b0;
            check({7'h00, busy, data_oe}, 9'h000);
        end
        wrap_up();
    end
endmodule : test_sbn_master
